// ==== core/iorg_output_regs.sv ====
// Read-only output register set for angular rate and acceleration samples.
// Assumes the data path presents full 32-bit samples with a one-cycle update strobe,
// and that the serial front end issues word reads by byte address.
// Function
// - Every axis is one 32-bit two's complement value; all but accel Y are split into high and low words, accel Y maps only its low word.
// - Rate high word is two's complement, zero at rest, LSB is one over scale.
// - Rate low word carries all 16 extra fractional resolution bits.
// - Rate map: X 0x04/0x06, Y 0x08/0x0A, Z 0x0C/0x0E, low word first.
// - Accel map: X low 0x10, X high 0x12, Y low 0x14.
// - All output words read-only, no default value, never kept in flash.
// - Accel high word two's complement, 40 g range, 1.25 milli-g per LSB.
// - Accel low word carries all 16 extra fractional resolution bits.
// - Acceleration includes gravity, on the same axes used for rotation.
// - Rate scale is 160, 40 or 10 counts per degree per second.
`timescale 1ns/100ps
`default_nettype none
module iorg_output_regs
   import iorg_pkg::*;
#(
   parameter int RATE_SCALE = iorg_pkg::RATE_SCALE_LOW
) (
   input  wire logic                      core_clk_in,
   input  wire logic                      arst_n_in,
   input  wire logic                      sample_valid_in,
   input  wire iorg_pkg::iorg_sample_type sample_in,
   input  wire iorg_pkg::iorg_rd_req_type rd_req_in,
   input  wire logic                      wr_in,
   output logic                           rd_valid_out,
   output logic                           rd_hit_out,
   output logic      [15:0]               rd_data_out,
   output logic      [7:0]                rate_scale_out
);
   import iorg_pkg::*;

   typedef enum logic [1:0] {
      IORG_IDLE = 2'b00,
      IORG_READ = 2'b01
   } iorg_state_type;

   iorg_state_type              state_q;
   iorg_state_type              state_d;
   logic                        hit_q;
   logic                        hit_d;
   logic [IORG_IDX_W-1:0]       idx;
   logic [IORG_NUM_WORDS*IORG_WORD_W-1:0] words;
   logic [IORG_WORD_W-1:0]      mem_rd_data;

   // Refuse any scale outside the three variants; checked once at elaboration
   if (RATE_SCALE != RATE_SCALE_LOW && RATE_SCALE != RATE_SCALE_MED &&
       RATE_SCALE != RATE_SCALE_HIGH) begin : g_scale_check
      $error("iorg_output_regs: RATE_SCALE must be 160, 40 or 10");
   end

   // Address decode to word index; odd and unlisted addresses miss
   function automatic logic [IORG_IDX_W-1:0] decode_addr(input logic [6:0] a);
      case (a)
         ADDR_RATE_X_FRACTION:  decode_addr = 4'h0;
         ADDR_RATE_X_UPPER:     decode_addr = 4'h1;
         ADDR_RATE_Y_FRACTION:  decode_addr = 4'h2;
         ADDR_RATE_Y_UPPER:     decode_addr = 4'h3;
         ADDR_RATE_Z_FRACTION:  decode_addr = 4'h4;
         ADDR_RATE_Z_UPPER:     decode_addr = 4'h5;
         ADDR_ACCEL_X_FRACTION: decode_addr = 4'h6;
         ADDR_ACCEL_X_UPPER:    decode_addr = 4'h7;
         ADDR_ACCEL_Y_FRACTION: decode_addr = 4'h8;
         default:               decode_addr = IDX_NONE;
      endcase
   endfunction

   assign idx = decode_addr(rd_req_in.addr);

   // Samples arrive already scaled and gravity-inclusive; this block only splits them
   assign words = {
      sample_in.accel_y[IORG_LO_MSB:IORG_LO_LSB],
      sample_in.accel_x[IORG_HI_MSB:IORG_HI_LSB],
      sample_in.accel_x[IORG_LO_MSB:IORG_LO_LSB],
      sample_in.rate_z[IORG_HI_MSB:IORG_HI_LSB],
      sample_in.rate_z[IORG_LO_MSB:IORG_LO_LSB],
      sample_in.rate_y[IORG_HI_MSB:IORG_HI_LSB],
      sample_in.rate_y[IORG_LO_MSB:IORG_LO_LSB],
      sample_in.rate_x[IORG_HI_MSB:IORG_HI_LSB],
      sample_in.rate_x[IORG_LO_MSB:IORG_LO_LSB]
   };

   // One write strobe loads every word at once so halves never mix samples
   iorg_word_mem #(
      .WIDTH (IORG_WORD_W),
      .DEPTH (IORG_NUM_WORDS),
      .IDX_W (IORG_IDX_W)
   ) u_mem (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .wr_all_in   (sample_valid_in),
      .wr_data_in  (words),
      .rd_in       (rd_req_in.rd),
      .rd_idx_in   (idx),
      .rd_data_out (mem_rd_data)
   );

   always_comb begin
      state_d = IORG_IDLE;
      hit_d   = hit_q;
      case (state_q)
         IORG_IDLE,
         IORG_READ: begin
            if (rd_req_in.rd) begin
               state_d = IORG_READ;
               hit_d   = (idx != IDX_NONE);
            end
         end
         default: state_d = IORG_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= IORG_IDLE;
         hit_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         hit_q   <= hit_d;
      end
   end

   // Writes are ignored: nothing here is writable or backed up
   assign rd_valid_out   = (state_q == IORG_READ);
   assign rd_hit_out     = hit_q;
   // The memory read register already holds zero after a miss, so data leave a flip-flop
   assign rd_data_out    = mem_rd_data;
   assign rate_scale_out = 8'(RATE_SCALE);

   wire unused_wr = wr_in;
endmodule
`default_nettype wire

// ==== core/iorg_pkg.sv ====
// Package for the inertial output register block: map, widths, field layout, scale constants.
// Assumes a single 25 MHz core clock and an internal data path that delivers whole samples.
package iorg_pkg;
   localparam int          IORG_WORD_W      = 16;
   localparam int          IORG_SAMPLE_W    = 32;
   localparam int          IORG_ADDR_W      = 7;
   localparam int          IORG_NUM_WORDS   = 9;
   localparam int          IORG_IDX_W       = 4;
   localparam int          IORG_HI_LSB      = 16;
   localparam int          IORG_HI_MSB      = 31;
   localparam int          IORG_LO_MSB      = 15;
   localparam int          IORG_LO_LSB      = 0;
   // Byte addresses of each word, low word first for every axis
   localparam logic [6:0] ADDR_RATE_X_FRACTION  = 7'h04;
   localparam logic [6:0] ADDR_RATE_X_UPPER     = 7'h06;
   localparam logic [6:0] ADDR_RATE_Y_FRACTION  = 7'h08;
   localparam logic [6:0] ADDR_RATE_Y_UPPER     = 7'h0A;
   localparam logic [6:0] ADDR_RATE_Z_FRACTION  = 7'h0C;
   localparam logic [6:0] ADDR_RATE_Z_UPPER     = 7'h0E;
   localparam logic [6:0] ADDR_ACCEL_X_FRACTION = 7'h10;
   localparam logic [6:0] ADDR_ACCEL_X_UPPER    = 7'h12;
   localparam logic [6:0] ADDR_ACCEL_Y_FRACTION = 7'h14;
   localparam logic [3:0] IDX_NONE              = 4'hF;
   localparam logic [15:0] IORG_UNMAPPED_DATA   = 16'h0000;
   // Rate scale factors, counts per degree per second, by dynamic range variant
   localparam int          RATE_SCALE_LOW   = 160;
   localparam int          RATE_SCALE_MED   = 40;
   localparam int          RATE_SCALE_HIGH  = 10;
   // Acceleration: 1 LSB of the upper word is 1.25 milli-g, full range 40 g
   localparam int          ACCEL_LSB_UMG    = 1250;
   localparam int          ACCEL_RANGE_G    = 40;

   typedef struct packed {
      logic [31:0] rate_x;
      logic [31:0] rate_y;
      logic [31:0] rate_z;
      logic [31:0] accel_x;
      logic [31:0] accel_y;
   } iorg_sample_type;

   typedef struct packed {
      logic        rd;
      logic [6:0]  addr;
   } iorg_rd_req_type;
endpackage

// ==== core/iorg_word_mem.sv ====
// Small register memory holding the output words of one sample set.
// Whole-set write in one cycle; read data come out of a flip-flop.
`timescale 1ns/100ps
`default_nettype none
module iorg_word_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 9,
   parameter int IDX_W = 4
) (
   input  wire logic                   core_clk_in,
   input  wire logic                   arst_n_in,
   input  wire logic                   wr_all_in,
   input  wire logic [DEPTH*WIDTH-1:0] wr_data_in,
   input  wire logic                   rd_in,
   input  wire logic [IDX_W-1:0]       rd_idx_in,
   output logic      [WIDTH-1:0]       rd_data_out
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [WIDTH-1:0] rd_data_q;
   logic [WIDTH-1:0] rd_data_d;

   // One index value stays free to mean no word, so DEPTH must leave it unused
   if (WIDTH < 1 || DEPTH < 1 || DEPTH > (1 << IDX_W) - 1) begin : g_size_check
      $error("iorg_word_mem: WIDTH, DEPTH or IDX_W out of range");
   end

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = wr_all_in ? wr_data_in[i*WIDTH +: WIDTH] : mem_q[i];
      end
      rd_data_d = rd_data_q;
      if (rd_in) begin
         rd_data_d = (int'(rd_idx_in) < DEPTH) ? mem_q[rd_idx_in] : '0;
      end
   end

   // Contents have no defined value on power-up; the reset only gives them a known state
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         rd_data_q <= '0;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
         end
         rd_data_q <= rd_data_d;
      end
   end

   assign rd_data_out = rd_data_q;
endmodule
`default_nettype wire

// ==== tb/iorg_host_model.sv ====
// Host model issuing word reads on the block's read request port.
// Assumes one answer per request, one cycle after the request edge.
`timescale 1ns/100ps
`default_nettype none
module iorg_host_model
   import iorg_pkg::*;
(
   input  wire logic                     core_clk_in,
   input  wire logic                     rd_valid_in,
   input  wire logic                     rd_hit_in,
   input  wire logic [15:0]              rd_data_in,
   output var iorg_pkg::iorg_rd_req_type rd_req_out
);
   initial rd_req_out = '{rd: 1'b0, addr: 7'h7F};
   // Leaves rd up between calls: the previous word is read once more, harmless since
   // reads have no side effects, and back-to-back reads stay exercised
   task automatic read(input logic [6:0] a, output logic [15:0] d, output logic [1:0] f);
      @(posedge core_clk_in);
      rd_req_out <= '{rd: 1'b1, addr: a};
      @(posedge core_clk_in);
      #1;
      d = rd_data_in;
      f = {rd_valid_in, rd_hit_in};
   endtask
   // Idle address is inverted so a stale address is never mistaken for a live one
   task automatic idle();
      @(posedge core_clk_in);
      rd_req_out <= '{rd: 1'b0, addr: ~rd_req_out.addr};
   endtask
endmodule
`default_nettype wire

// ==== tb/iorg_output_regs_sva.sv ====
// Checker for the inertial output registers, bound to the block's top module.
// Assumes reads are taken at the rd edge and answered one cycle later.
`timescale 1ns/100ps
`default_nettype none
module iorg_output_regs_sva
   import iorg_pkg::*;
#(parameter int RATE_SCALE = 160) (
   input wire logic                      core_clk_in,
   input wire logic                      arst_n_in,
   input wire logic                      sample_valid_in,
   input wire iorg_pkg::iorg_sample_type sample_in,
   input wire iorg_pkg::iorg_rd_req_type rd_req_in,
   input wire logic                      wr_in,
   input wire logic                      rd_valid_out,
   input wire logic                      rd_hit_out,
   input wire logic [15:0]               rd_data_out,
   input wire logic [7:0]                rate_scale_out
);
   iorg_sample_type last_q, last_d;
   logic [15:0]     exp_w;
   logic            exp_hit;
   int              k;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   // Shadow of the last loaded sample; a read in the update cycle sees the old one
   always_comb begin
      last_d  = sample_valid_in ? sample_in : last_q;
      k       = (int'(rd_req_in.addr) - 4) / 2;
      exp_hit = !rd_req_in.addr[0] && k >= 0 && k <= 8;
      exp_w   = exp_hit ? last_q[128 - 16 * k + 32 * (k % 2) +: 16] : 16'h0000;
   end
   always_ff @(posedge core_clk_in or negedge arst_n_in)
      if (!arst_n_in) last_q <= '0;
      else last_q <= last_d;
   sequence s_b2b; rd_req_in.rd ##1 rd_req_in.rd; endsequence
   sequence s_upd; sample_valid_in && rd_req_in.rd && exp_hit; endsequence
   property p_answer; rd_req_in.rd |=> rd_valid_out; endproperty
   property p_b2b; s_b2b |=> rd_valid_out && $past(rd_valid_out); endproperty
   property p_rate;
      rd_req_in.rd && exp_hit && rd_req_in.addr < 7'h10
         |=> rd_hit_out && rd_data_out == $past(exp_w);
   endproperty
   property p_accel;
      rd_req_in.rd && exp_hit && rd_req_in.addr > 7'h0F
         |=> rd_hit_out && rd_data_out == $past(exp_w);
   endproperty
   property p_miss;
      rd_req_in.rd && !exp_hit |=> !rd_hit_out && rd_data_out == 16'h0000;
   endproperty
   property p_hold; !rd_req_in.rd |=> $stable(rd_data_out) && $stable(rd_hit_out); endproperty
   property p_stale; s_upd |=> rd_data_out == $past(exp_w); endproperty
   property p_scale; rate_scale_out == 8'(RATE_SCALE); endproperty
   a_answer: assert property (p_answer) else $error("read unanswered");
   a_b2b: assert property (p_b2b) else $error("back to back read lost");
   a_rate: assert property (p_rate) else $error("rate word wrong");
   a_accel: assert property (p_accel) else $error("accel word wrong");
   a_miss: assert property (p_miss) else $error("unmapped read hit");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_stale: assert property (p_stale) else $error("torn sample");
   a_scale: assert property (p_scale) else $error("scale wrong");
endmodule
bind iorg_output_regs iorg_output_regs_sva #(.RATE_SCALE(RATE_SCALE)) u_sva (.core_clk_in,
   .arst_n_in, .sample_valid_in, .sample_in, .rd_req_in, .wr_in, .rd_valid_out, .rd_hit_out,
   .rd_data_out, .rate_scale_out);
`default_nettype wire

// ==== tb/test_iorg_output_regs.sv ====
// Self-checking bench for the inertial output registers.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module test_iorg_output_regs;
   import iorg_pkg::*;
   localparam iorg_sample_type S1 = '{32'h4E200000, 32'hFFFFFFFF, 32'hB1E00000, 32'h7D000000,
      32'h83000001};
   localparam iorg_sample_type S2 = '{32'h00000000, 32'h00000001, 32'hFFFFFFFE, 32'h00000000,
      32'h12345678};
   logic            core_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            sv = 1'b0;
   logic            wr = 1'b0;
   iorg_sample_type s = '0;
   iorg_rd_req_type req;
   logic            v, h;
   logic [15:0]     d;
   logic [7:0]      sc;
   logic [6:0]      bad [4] = '{7'h00, 7'h05, 7'h16, 7'h7F};
   int              n_mismatch = 0;
   int              compares = 0;
   always #20 core_clk = ~core_clk;
   iorg_output_regs #(.RATE_SCALE(40)) u_dut (.core_clk_in(core_clk), .arst_n_in(rst_n),
      .sample_valid_in(sv), .sample_in(s), .rd_req_in(req), .wr_in(wr), .rd_valid_out(v),
      .rd_hit_out(h), .rd_data_out(d), .rate_scale_out(sc));
   iorg_host_model u_host (.core_clk_in(core_clk), .rd_valid_in(v), .rd_hit_in(h),
      .rd_data_in(d), .rd_req_out(req));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic load(input iorg_sample_type x);
      @(posedge core_clk);
      s <= x;
      sv <= 1'b1;
      @(posedge core_clk);
      sv <= 1'b0;
   endtask
   task automatic read_all(input iorg_sample_type x);
      logic [31:0] ax [5];
      logic [15:0] w;
      logic [1:0]  f;
      ax = '{x.rate_x, x.rate_y, x.rate_z, x.accel_x, x.accel_y};
      for (int j = 0; j < 9; j++) begin
         u_host.read(7'(4 + 2 * j), w, f);
         check(w, (j % 2) ? ax[j / 2][31:16] : ax[j / 2][15:0]);
         check({14'h0000, f}, 16'h0003);
      end
      u_host.idle();
   endtask
   initial begin
      logic [15:0] w;
      logic [1:0]  f;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      load(S1);
      check({8'h00, sc}, 16'h0028);
      read_all(S1);
      $display("test map done");
      // Update lands on the same edge as the read: the old word must come back
      fork
         u_host.read(ADDR_RATE_X_UPPER, w, f);
         load(S2);
      join
      check(w, S1.rate_x[31:16]);
      u_host.idle();
      wr <= 1'b1;
      read_all(S2);
      wr <= 1'b0;
      $display("test update done");
      foreach (bad[i]) begin
         u_host.read(bad[i], w, f);
         check(w, 16'h0000);
         check({14'h0000, f}, 16'h0002);
      end
      u_host.idle();
      $display("test unmapped done");
      stop_test();
   end
   initial begin
      repeat (2000) @(posedge core_clk);
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
